// ### pkg/arsp_pkg.sv
package arsp_pkg;
   // -----------------------------------------------------------------
   // register byte addresses on the apb slave
   // -----------------------------------------------------------------
   localparam logic [7:0] ARSP_SEQ_OFS = 8'h00;
   localparam logic [7:0] ARSP_CFG_OFS = 8'h04;
   localparam logic [7:0] ARSP_FLAGS_OFS = 8'h08;
   localparam logic [7:0] ARSP_DIEN_OFS = 8'h0C;
   localparam logic [7:0] ARSP_PINS_OFS = 8'h10;
   localparam logic [7:0] ARSP_IRQ_ST_OFS = 8'h14;
   localparam logic [7:0] ARSP_IRQ_MASK_OFS = 8'h18;
   // result register n sits at 8'h20 + 4*n
   localparam logic [2:0] ARSP_RES_PAGE = 3'h1;
   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int ARSP_JUSTIFY_BIT = 0;
   localparam int ARSP_SIGNED_BIT = 1;
   localparam int ARSP_FAST_BIT = 0;
   localparam int ARSP_TRIG_EN_BIT = 1;
   localparam int ARSP_TRIG_SRC_BIT = 2;
   localparam int ARSP_RES8_BIT = 3;
   localparam int ARSP_TRIG_CH_LSB = 4;
   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] ARSP_BYTE_RST = 8'h00;
   localparam logic [7:0] ARSP_PINS_RST = 8'hFF;
   localparam logic [15:0] ARSP_RES_RST = 16'h0000;
   localparam logic [31:0] ARSP_WORD_ZERO = 32'h0000_0000;
   // apb phase of the slave
   typedef enum logic [0:0] {
      ARSP_IDLE = 1'b0,
      ARSP_ACCESS = 1'b1
   } arsp_phase_t;
endpackage

// ### hdl/arsp_top.sv
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
// Contract
// (R1) each finished conversion sets one done flag, eight sequence positions
// (R2) flag n and result register n belong to the n-th conversion
// (R3) writing the sequence start register clears all done flags
// (R4) fast clear off: status read then result x read clears flag x
// (R5) fast clear on: any read of result x clears flag x
// (R6) set beats read clears; sequence start clear beats set
// (R7) done flags readable always, writes to them do nothing
// (R8) input enable bit x gates pin x buffer; register read/write
// (R9) pin bit reads live level if enabled or selected trigger pin
// (R10) disabled and not trigger pin: pin bit reads one
// (R11) reset forces every pin level bit to one
// (R12) pin level register readable, writes ignored
// (R13) eight result registers, readable, writable only in special mode
// (R14) justify and signed selects in sequence start register format data
// (R15) signed is two's complement, left only; right ignores signed
// (R16) left: high byte holds bits 9:2 or 7:0, resets zero
// (R17) left: low byte bits 1:0 at 7:6, rest zero, resets zero
// (R18) right: result in low bits, upper bits read zero
module arsp_top
   import arsp_pkg::*;
#(
   parameter int NCH = 8,
   parameter int RES_W = 10
)
(
   // clock, reset, enable
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sequencer side
   input wire logic conv_valid,
   input wire logic [RES_W-1:0] conv_data,
   output logic seq_start,
   // pads and mode
   input wire logic [NCH-1:0] analog_pin,
   input wire logic special_mode,
   output logic [NCH-1:0] input_buffer_enable_bit,
   // interrupt
   output logic irq
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   arsp_phase_t phase_q;
   logic [31:0] prdata_q;
   logic err_q;
   logic [7:0] sequence_start_control_q;
   logic [7:0] cfg_q;
   logic [NCH-1:0] conversion_done_flags_q;
   logic [NCH-1:0] armed_q;
   logic [NCH-1:0] digital_input_enable_q;
   logic [NCH-1:0] pin_input_levels_q;
   logic [NCH-1:0] irq_st_q;
   logic [NCH-1:0] irq_mask_q;
   logic [2:0] pos_q;
   logic seq_start_q;
   logic [15:0] result_register_q [NCH];
   logic [15:0] fmt_d;
   logic [NCH-1:0] set_v;
   logic [NCH-1:0] clr_rd;
   logic done;
   logic wr;
   logic rd;
   logic seq_wr;
   logic res_hit;
   logic [2:0] res_idx;
   logic rd_res;
   logic rd_flags;
   logic fast_flag_clear;
   logic trigger_enable;
   logic trigger_source_select;
   logic [2:0] trigger_channel_select;
   logic left_just;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   // pready is held low while ce is low so an access frozen after its setup cycle is not lost
   assign pready = ce & (phase_q == ARSP_ACCESS);
   assign pslverr = pready & err_q;
   assign prdata = prdata_q;
   assign done = psel & penable & pready;
   assign wr = done & pwrite;
   assign rd = done & ~pwrite;
   assign seq_wr = wr & (paddr == ARSP_SEQ_OFS);
   assign res_hit = (paddr[7:5] == ARSP_RES_PAGE) & (paddr[1:0] == 2'h0);
   assign res_idx = paddr[4:2];
   assign rd_res = rd & res_hit;
   assign rd_flags = rd & (paddr == ARSP_FLAGS_OFS);

   // configuration fields
   assign fast_flag_clear = cfg_q[ARSP_FAST_BIT];
   assign trigger_enable = cfg_q[ARSP_TRIG_EN_BIT];
   assign trigger_source_select = cfg_q[ARSP_TRIG_SRC_BIT];
   assign trigger_channel_select = cfg_q[ARSP_TRIG_CH_LSB +: 3];
   assign left_just = ~sequence_start_control_q[ARSP_JUSTIFY_BIT];
   assign input_buffer_enable_bit = digital_input_enable_q;
   assign seq_start = seq_start_q;
   assign irq = |(irq_st_q & irq_mask_q);

   // phase tracker: setup cycle arms, completing edge disarms
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         phase_q <= ARSP_IDLE;
      else if (ce)
      begin
         case (phase_q)
            ARSP_IDLE:
               if (psel && !penable)
                  phase_q <= ARSP_ACCESS;
            ARSP_ACCESS:
               if (!psel || penable)
                  phase_q <= ARSP_IDLE;
            default:
               phase_q <= ARSP_IDLE;
         endcase
      end
   end

   // read data captured in the setup cycle so prdata comes from a flop
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         prdata_q <= ARSP_WORD_ZERO;
         err_q <= 1'b0;
      end
      else if (ce && psel && !penable)
      begin
         err_q <= 1'b0;
         prdata_q <= ARSP_WORD_ZERO;
         case (paddr)
            ARSP_SEQ_OFS: prdata_q[7:0] <= sequence_start_control_q;
            ARSP_CFG_OFS: prdata_q[7:0] <= cfg_q;
            ARSP_FLAGS_OFS: prdata_q[NCH-1:0] <= conversion_done_flags_q; // R7
            ARSP_DIEN_OFS: prdata_q[NCH-1:0] <= digital_input_enable_q; // R8
            ARSP_PINS_OFS: prdata_q[NCH-1:0] <= pin_input_levels_q; // R12
            ARSP_IRQ_ST_OFS: prdata_q[NCH-1:0] <= irq_st_q;
            ARSP_IRQ_MASK_OFS: prdata_q[NCH-1:0] <= irq_mask_q;
            default:
               if (res_hit)
                  prdata_q[15:0] <= result_register_q[res_idx]; // R13
               else
                  err_q <= 1'b1;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   // the sequence start write also pulses seq_start to the sequencer
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sequence_start_control_q <= ARSP_BYTE_RST;
         cfg_q <= ARSP_BYTE_RST;
         digital_input_enable_q <= ARSP_BYTE_RST;
         irq_mask_q <= ARSP_BYTE_RST;
         seq_start_q <= 1'b0;
      end
      else if (ce)
      begin
         seq_start_q <= seq_wr;
         if (seq_wr)
            sequence_start_control_q <= pwdata[7:0]; // R14
         if (wr && paddr == ARSP_CFG_OFS)
            cfg_q <= pwdata[7:0];
         if (wr && paddr == ARSP_DIEN_OFS)
            digital_input_enable_q <= pwdata[NCH-1:0]; // R8
         if (wr && paddr == ARSP_IRQ_MASK_OFS)
            irq_mask_q <= pwdata[NCH-1:0];
      end
   end

   // sequence position: restarts on a new sequence, wraps after eight
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         pos_q <= 3'h0;
      else if (ce)
      begin
         if (seq_wr)
            pos_q <= 3'h0;
         else if (conv_valid)
            pos_q <= pos_q + 3'h1; // R2
      end
   end

   // ----------------------------------------------------------------
   // result formatting
   // ----------------------------------------------------------------
   // eight bit mode leaves the low byte top bits undefined; zero is used
   always_comb
   begin
      fmt_d = ARSP_RES_RST;
      if (left_just)
      begin
         if (cfg_q[ARSP_RES8_BIT])
            fmt_d = {conv_data[7:0], 8'h00}; // R16
         else
            fmt_d = {conv_data[9:0], 6'h00}; // R17
         if (sequence_start_control_q[ARSP_SIGNED_BIT])
            fmt_d[15] = ~fmt_d[15]; // R15
      end
      else if (cfg_q[ARSP_RES8_BIT])
         fmt_d = {8'h00, conv_data[7:0]}; // R18
      else
         fmt_d = {6'h00, conv_data[9:0]}; // R18 R15
   end

   // ----------------------------------------------------------------
   // per channel flags, results, pins, interrupt status
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++)
      begin : g_ch
         assign set_v[gi] = conv_valid & (pos_q == 3'(gi)); // R1
         assign clr_rd[gi] = rd_res & (res_idx == 3'(gi))
            & (fast_flag_clear | armed_q[gi]); // R4 R5

         // start clear wins over set; set wins over read clears
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               conversion_done_flags_q[gi] <= 1'b0;
            else if (ce)
            begin
               if (seq_wr)
                  conversion_done_flags_q[gi] <= 1'b0; // R3 R6
               else if (set_v[gi])
                  conversion_done_flags_q[gi] <= 1'b1; // R1 R6
               else if (clr_rd[gi])
                  conversion_done_flags_q[gi] <= 1'b0; // R4 R5
            end
         end

         // status read arms the two step clear of each flag
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               armed_q[gi] <= 1'b0;
            else if (ce)
            begin
               if (rd_flags)
                  armed_q[gi] <= 1'b1; // R4
               else if (seq_wr || (rd_res && res_idx == 3'(gi)))
                  armed_q[gi] <= 1'b0;
            end
         end

         // results load on their own conversion; test writes in special
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               result_register_q[gi] <= ARSP_RES_RST; // R16 R17
            else if (ce)
            begin
               if (set_v[gi])
                  result_register_q[gi] <= fmt_d; // R2 R14
               else if (wr && res_hit && res_idx == 3'(gi) && special_mode)
                  result_register_q[gi] <= pwdata[15:0]; // R13
            end
         end

         // digital input path; a disabled buffer reads as one unless it is the selected trigger pin
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               pin_input_levels_q[gi] <= 1'b1; // R11
            else if (ce)
            begin
               if (digital_input_enable_q[gi] || (trigger_enable
                  && !trigger_source_select
                  && trigger_channel_select == 3'(gi)))
                  pin_input_levels_q[gi] <= analog_pin[gi]; // R9
               else
                  pin_input_levels_q[gi] <= 1'b1; // R10
            end
         end

         // sticky event bit, write one clears, a new set wins
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               irq_st_q[gi] <= 1'b0;
            else if (ce)
            begin
               if (set_v[gi])
                  irq_st_q[gi] <= 1'b1;
               else if (wr && paddr == ARSP_IRQ_ST_OFS && pwdata[gi])
                  irq_st_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_flag_sets: assert property ( // R1
      (ce && conv_valid && !seq_wr)
      |=> conversion_done_flags_q[$past(pos_q)])
      else $error("done flag not set after conversion");

   a_result_pairs: assert property ( // R2
      (ce && conv_valid && !seq_wr)
      |=> result_register_q[$past(pos_q)] == $past(fmt_d))
      else $error("result not stored at flag position");

   a_start_clears: assert property ( // R3
      (ce && seq_wr) |=> conversion_done_flags_q == '0)
      else $error("sequence start left a flag set");

   a_two_step_clear: assert property ( // R4
      (ce && !fast_flag_clear && rd_res && armed_q[res_idx]
      && !conv_valid && !seq_wr)
      |=> !conversion_done_flags_q[$past(res_idx)])
      else $error("status then result read did not clear");

   a_no_early_clear: assert property ( // R4
      (ce && !fast_flag_clear && rd_res && !armed_q[res_idx]
      && conversion_done_flags_q[res_idx] && !seq_wr)
      |=> conversion_done_flags_q[$past(res_idx)])
      else $error("result read cleared without status read");

   a_fast_clear: assert property ( // R5
      (ce && fast_flag_clear && rd_res && !conv_valid && !seq_wr)
      |=> !conversion_done_flags_q[$past(res_idx)])
      else $error("fast clear failed");

   a_set_beats_read: assert property ( // R6
      (ce && rd_res && conv_valid && pos_q == res_idx && !seq_wr)
      |=> conversion_done_flags_q[$past(res_idx)])
      else $error("read clear beat a set");

   a_flags_no_write: assert property ( // R7
      (ce && wr && paddr == ARSP_FLAGS_OFS && !conv_valid && !rd)
      |=> $stable(conversion_done_flags_q))
      else $error("write changed done flags");

   a_pin_disabled: assert property ( // R10
      (ce && !digital_input_enable_q[0] && !trigger_enable)
      |=> pin_input_levels_q[0])
      else $error("disabled pin did not read one");

   a_pin_live: assert property ( // R9
      (ce && digital_input_enable_q[1])
      |=> pin_input_levels_q[1] == $past(analog_pin[1]))
      else $error("enabled pin not live");

   a_right_unsigned: assert property ( // R15
      (ce && conv_valid && !seq_wr && !left_just)
      |=> result_register_q[$past(pos_q)][15:RES_W] == '0)
      else $error("right justified upper bits not zero");

   a_left_low_zero: assert property ( // R17
      (ce && conv_valid && !seq_wr && left_just)
      |=> result_register_q[$past(pos_q)][5:0] == '0)
      else $error("left justified low bits not zero");

   c_fast_clear: cover property (ce && fast_flag_clear && clr_rd != '0);
   c_two_step: cover property (rd_flags ##[1:4] (rd_res && !fast_flag_clear));
   c_start_vs_set: cover property (ce && seq_wr && conv_valid);
   c_signed_left: cover property (ce && conv_valid && left_just
      && sequence_start_control_q[ARSP_SIGNED_BIT]);
endmodule

// ### testbench/adc_result_status_port_test.sv
`timescale 1ns/1ps
module adc_result_status_port_test;
   import arsp_pkg::*;
   // -----------------------------------------------------------------
   // stimulus and observed signals
   // -----------------------------------------------------------------
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic conv_valid = 1'b0;
   logic [9:0] conv_data = 10'h000;
   logic seq_start;
   logic [7:0] analog_pin = 8'h00;
   logic special_mode = 1'b0;
   logic ce = 1'b1;
   logic [7:0] input_buffer_enable_bit;
   logic irq;
   int err_total = 0;
   int checks_done = 0;
   logic [31:0] rv;
   logic ev;
   logic [9:0] dv;

   // 10 mhz clock
   always #50 clk = ~clk;

   arsp_top arsp_top_inst (.clk(clk), .reset_n(reset_n), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_valid(conv_valid), .conv_data(conv_data),
      .seq_start(seq_start), .analog_pin(analog_pin),
      .special_mode(special_mode),
      .input_buffer_enable_bit(input_buffer_enable_bit), .irq(irq));

   // -----------------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] s, e);
      checks_done++;
      if (s !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
         err_total++;
      end
   endtask

   // pready, data and error are looked at mid-cycle; they stand until the
   // completing edge, so that edge is never raced
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(negedge clk); while (pready !== 1'b1);
      rv = prdata;
      ev = pslverr;
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk($sformatf("reg %h", a), rv, e);
   endtask

   task automatic conv(input logic [9:0] d);
      @(posedge clk);
      conv_valid <= 1'b1;
      conv_data <= d;
      @(posedge clk);
      conv_valid <= 1'b0;
   endtask

   function automatic logic [7:0] ra(input int n);
      return 8'h20 + 8'(4 * n);
   endfunction

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_reset;
      rd(ARSP_FLAGS_OFS, 32'h0000_0000);
      rd(ARSP_DIEN_OFS, 32'h0000_0000);
      rd(ARSP_PINS_OFS, 32'h0000_00FF);
      rd(ra(0), 32'h0000_0000);
      chk("irq", {31'h0, irq}, 32'h0000_0000);
      $display("test reset done");
   endtask

   // eight conversions, then reads without and with the status read
   task automatic t_seq;
      apb(1'b1, ARSP_SEQ_OFS, 32'h0000_0000);
      @(negedge clk);
      chk("seq start", {31'h0, seq_start}, 32'h0000_0001);
      for (int i = 0; i < 8; i++)
         conv(10'h201 + 10'(i * 37));
      for (int i = 0; i < 8; i++)
         rd(ra(i), {16'h0, 10'h201 + 10'(i * 37), 6'h00});
      rd(ARSP_FLAGS_OFS, 32'h0000_00FF);
      apb(1'b1, ARSP_FLAGS_OFS, 32'h0000_0000);
      rd(ARSP_FLAGS_OFS, 32'h0000_00FF);
      rd(ra(3), {16'h0, 10'h201 + 10'(3 * 37), 6'h00});
      rd(ARSP_FLAGS_OFS, 32'h0000_00F7);
      apb(1'b1, ARSP_CFG_OFS, 32'h0000_0001);
      apb(1'b1, ARSP_SEQ_OFS, 32'h0000_0000);
      rd(ARSP_FLAGS_OFS, 32'h0000_0000);
      conv(10'h201);
      conv(10'h0AA);
      // fast clear is on, and the status read after the start armed every flag
      rd(ra(0), {16'h0, 10'h201, 6'h00});
      rd(ARSP_FLAGS_OFS, 32'h0000_0002);
      // conversion into slot 2 lands on the same edge as its read
      fork
         rd(ra(2), {16'h0, 10'h201 + 10'(2 * 37), 6'h00});
         begin
            @(posedge clk);
            conv(10'h3FF);
         end
      join
      rd(ARSP_FLAGS_OFS, 32'h0000_0006);
      $display("test sequence done");
   endtask

   // every justify and sign combination, then 8-bit left and right
   task automatic t_fmt;
      logic [15:0] e;
      dv = 10'h2C5;
      for (int m = 0; m < 4; m++)
      begin
         apb(1'b1, ARSP_CFG_OFS, 32'h0000_0000);
         apb(1'b1, ARSP_SEQ_OFS, 32'(m));
         conv(dv);
         e = (m == 0) ? {dv, 6'h00} :
             (m == 2) ? {~dv[9], dv[8:0], 6'h00} : {6'h00, dv};
         rd(ra(0), {16'h0, e});
      end
      apb(1'b1, ARSP_CFG_OFS, 32'h0000_0008);
      apb(1'b1, ARSP_SEQ_OFS, 32'h0000_0000);
      conv(dv);
      rd(ra(0), {16'h0, dv[7:0], 8'h00});
      apb(1'b1, ARSP_SEQ_OFS, 32'h0000_0001);
      conv(dv);
      rd(ra(0), {24'h0, dv[7:0]});
      apb(1'b1, ARSP_CFG_OFS, 32'h0000_0000);
      $display("test format done");
   endtask

   task automatic t_pins;
      analog_pin <= 8'hA5;
      apb(1'b1, ARSP_DIEN_OFS, 32'h0000_000F);
      rd(ARSP_DIEN_OFS, 32'h0000_000F);
      chk("ien", {24'h0, input_buffer_enable_bit}, 32'h0000_000F);
      rd(ARSP_PINS_OFS, 32'h0000_00F5);
      apb(1'b1, ARSP_CFG_OFS, 32'h0000_0062);
      rd(ARSP_PINS_OFS, 32'h0000_00B5);
      apb(1'b1, ARSP_CFG_OFS, 32'h0000_0066);
      rd(ARSP_PINS_OFS, 32'h0000_00F5);
      apb(1'b1, ARSP_PINS_OFS, 32'h0000_0000);
      rd(ARSP_PINS_OFS, 32'h0000_00F5);
      apb(1'b1, ARSP_CFG_OFS, 32'h0000_0000);
      $display("test pins done");
   endtask

   // sticky status, mask, write-one-clear, then bus error and test mode
   task automatic t_irq_err;
      apb(1'b1, ARSP_SEQ_OFS, 32'h0000_0000);
      apb(1'b1, ARSP_IRQ_ST_OFS, 32'h0000_00FF);
      apb(1'b1, ARSP_IRQ_MASK_OFS, 32'h0000_0000);
      conv(10'h155);
      conv(10'h0AA);
      @(negedge clk);
      chk("irq masked", {31'h0, irq}, 32'h0000_0000);
      apb(1'b1, ARSP_IRQ_MASK_OFS, 32'h0000_0002);
      @(negedge clk);
      chk("irq on", {31'h0, irq}, 32'h0000_0001);
      apb(1'b1, ARSP_IRQ_ST_OFS, 32'h0000_0002);
      @(negedge clk);
      chk("irq off", {31'h0, irq}, 32'h0000_0000);
      rd(ARSP_IRQ_ST_OFS, 32'h0000_0001);
      // a conversion while frozen must leave every flag alone
      ce <= 1'b0;
      conv(10'h3FF);
      ce <= 1'b1;
      rd(ARSP_FLAGS_OFS, 32'h0000_0003);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("slverr", {31'h0, ev}, 32'h0000_0001);
      apb(1'b1, ra(1), 32'h0000_1234);
      rd(ra(1), {16'h0, 10'h0AA, 6'h00});
      special_mode <= 1'b1;
      apb(1'b1, ra(1), 32'h0000_1234);
      rd(ra(1), 32'h0000_1234);
      special_mode <= 1'b0;
      $display("test irq and errors done");
   endtask

   // -----------------------------------------------------------------
   // verdict and run control
   // -----------------------------------------------------------------
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      stop_test;
   end

   // main sequence
   initial
   begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      t_reset;
      t_seq;
      t_fmt;
      t_pins;
      t_irq_err;
      stop_test;
   end
endmodule
